// ==== logic/sep_consts.vh ====
// constants for the serial eeprom command and protection front end
`ifndef SEP_CONSTS_VH
`define SEP_CONSTS_VH

// opcodes
`define SEP_OP_SET_LATCH   8'h06
`define SEP_OP_CLR_LATCH   8'h04
`define SEP_OP_STAT_READ   8'h05
`define SEP_OP_STAT_WRITE  8'h01
`define SEP_OP_MEM_READ    8'h03
`define SEP_OP_MEM_WRITE   8'h02

// status bit positions
`define SEP_ST_BUSY        0
`define SEP_ST_LATCH       1
`define SEP_ST_PROT_LO     2
`define SEP_ST_PROT_HI     3
`define SEP_ST_ID_LOCK     4
`define SEP_ST_ZERO        5
`define SEP_ST_ID_SEL      6
`define SEP_ST_PIN_GUARD   7

// block protect codes and range bottoms
`define SEP_BP_NONE        2'h0
`define SEP_BP_QUARTER     2'h1
`define SEP_BP_HALF        2'h2
`define SEP_BP_FULL        2'h3
`define SEP_QUARTER_BASE   14'h3000
`define SEP_HALF_BASE      14'h2000

// reset values
`define SEP_RST_PROT       2'h0
`define SEP_RST_GUARD      1'b0
`define SEP_RST_LOCK       1'b0

// timing
`define SEP_CLK_NS         25
`define SEP_TWC_NS         5000000
`define SEP_TWC_CYCLES     (`SEP_TWC_NS / `SEP_CLK_NS)

`endif

// ==== logic/sep_top.v ====
// spi slave front end: opcode decode, status register, write protection
`timescale 1ns/100ps
`include "sep_consts.vh"
module sep_top #(
	parameter WRITE_CYCLES = `SEP_TWC_CYCLES,
	parameter ADDR_W       = 14,
	parameter ID_ADDR_W    = 6
) (
	input  wire              clk_sys_i,
	input  wire              srst_i,
	input  wire              cs_n_i,
	input  wire              sck_i,
	input  wire              si_i,
	input  wire              hold_n_i,
	input  wire              wp_n_i,
	output reg               so_o,
	output reg               so_oe_o,
	output reg  [ADDR_W-1:0] rd_addr_o,
	output reg               rd_id_page_o,
	output reg               rd_en_o,
	input  wire [7:0]        rd_data_i,
	output reg  [ADDR_W+8:0] wr_word_o,
	output reg               wr_valid_o,
	input  wire              wr_ready_i,
	output reg               write_start_o,
	output reg  [7:0]        status_o
);

	localparam S_IDLE   = 3'h0;
	localparam S_OPC    = 3'h1;
	localparam S_ADDR   = 3'h2;
	localparam S_WDATA  = 3'h3;
	localparam S_RDATA  = 3'h4;
	localparam S_SREAD  = 3'h5;
	localparam S_SWRITE = 3'h6;
	localparam S_IGNORE = 3'h7;
	localparam WORD_W   = ADDR_W + 9;

	reg [2:0]        cs_s;
	reg [2:0]        sck_s;
	reg [1:0]        si_s;
	reg [1:0]        hold_s;
	reg [1:0]        wp_s;
	reg [2:0]        state;
	reg [3:0]        bit_cnt;
	reg [7:0]        in_sr;
	reg [7:0]        out_sr;
	reg [7:0]        opcode;
	reg [15:0]       addr;
	reg              latch;
	reg              latch_armed;
	reg [1:0]        prot;
	reg              guard;
	reg              id_sel;
	reg              id_lock;
	reg              busy;
	reg [31:0]       busy_cnt;
	reg              frame_bad;
	reg              got_byte;
	reg [7:0]        sw_byte;
	reg              was_write;
	reg              push_v;
	reg [WORD_W-1:0] push_d;
	reg [WORD_W-1:0] buf_mem1;
	reg [1:0]        buf_cnt;
	reg              rd_en_q;

	wire cs_low   = ~cs_s[1];
	wire cs_fall  = cs_s[2] & ~cs_s[1];
	wire cs_rise  = ~cs_s[2] & cs_s[1];
	// edges ignored while paused, so no bit moves during a hold
	wire run      = cs_low & hold_s[1];
	wire sck_rise = run & ~sck_s[2] & sck_s[1];
	wire sck_fall = run & sck_s[2] & ~sck_s[1];
	wire [7:0] in_byte = {in_sr[6:0], si_s[1]};
	wire hw_guard = guard & ~wp_s[1];
	wire [7:0] status = {guard, id_sel, 1'b0, id_lock, prot, latch, busy};
	wire [ADDR_W-1:0] cur_addr = addr[ADDR_W-1:0];
	wire buf_in_ready = (buf_cnt != 2'h2) | wr_ready_i;

	function prot_hit;
		input [1:0]        code;
		input [ADDR_W-1:0] a;
		begin
			case (code)
				`SEP_BP_QUARTER: prot_hit = (a >= `SEP_QUARTER_BASE);
				`SEP_BP_HALF:    prot_hit = (a >= `SEP_HALF_BASE);
				`SEP_BP_FULL:    prot_hit = 1'b1;
				default:         prot_hit = 1'b0;
			endcase
		end
	endfunction

	// byte is writable: main array outside range, id page also unlocked
	wire byte_ok = latch & ~prot_hit(prot, cur_addr) &
		(~id_sel | ~id_lock);

	// pin synchronisers
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			cs_s   <= 3'h7;
			sck_s  <= 3'h0;
			si_s   <= 2'h0;
			hold_s <= 2'h3;
			wp_s   <= 2'h3;
		end else begin
			cs_s   <= {cs_s[1:0], cs_n_i};
			sck_s  <= {sck_s[1:0], sck_i};
			si_s   <= {si_s[0], si_i};
			hold_s <= {hold_s[0], hold_n_i};
			wp_s   <= {wp_s[0], wp_n_i};
		end
	end

	// frame decoder, status register and write cycle timer
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			state         <= S_IDLE;
			bit_cnt       <= 4'h0;
			in_sr         <= 8'h00;
			out_sr        <= 8'hFF;
			opcode        <= 8'h00;
			addr          <= 16'h0000;
			latch         <= 1'b0;
			latch_armed   <= 1'b0;
			prot          <= `SEP_RST_PROT;
			guard         <= `SEP_RST_GUARD;
			id_sel        <= 1'b0;
			id_lock       <= `SEP_RST_LOCK;
			busy          <= 1'b0;
			busy_cnt      <= 32'h00000000;
			frame_bad     <= 1'b0;
			got_byte      <= 1'b0;
			sw_byte       <= 8'h00;
			was_write     <= 1'b0;
			push_v        <= 1'b0;
			push_d        <= {WORD_W{1'b0}};
			so_o          <= 1'b1;
			so_oe_o       <= 1'b0;
			rd_addr_o     <= {ADDR_W{1'b0}};
			rd_id_page_o  <= 1'b0;
			rd_en_o       <= 1'b0;
			write_start_o <= 1'b0;
			status_o      <= 8'h00;
		end else begin
			rd_en_o       <= 1'b0;
			write_start_o <= 1'b0;
			push_v        <= 1'b0;
			status_o      <= status;
			// a refused push would lose a byte, so the whole write is dropped
			if (push_v & ~buf_in_ready)
				frame_bad <= 1'b1;
			if (busy) begin
				if (busy_cnt <= 32'h00000001) begin
					busy  <= 1'b0;
					latch <= 1'b0;
					if (was_write)
						id_sel <= 1'b0;
				end
				busy_cnt <= busy_cnt - 32'h00000001;
			end
			so_oe_o <= run & (state == S_RDATA || state == S_SREAD);
			if (cs_fall) begin
				state       <= S_OPC;
				bit_cnt     <= 4'h0;
				frame_bad   <= 1'b0;
				got_byte    <= 1'b0;
				latch_armed <= 1'b0;
			end else if (cs_rise) begin
				state <= S_IDLE;
				if (latch_armed)
					latch <= 1'b1;
				if (state == S_SWRITE && got_byte && bit_cnt == 4'h0 && latch && ~hw_guard) begin
					guard <= sw_byte[`SEP_ST_PIN_GUARD];
					prot  <= sw_byte[`SEP_ST_PROT_HI:`SEP_ST_PROT_LO];
					if (~(sw_byte[`SEP_ST_ID_SEL] & sw_byte[`SEP_ST_ID_LOCK])) begin
						id_sel  <= sw_byte[`SEP_ST_ID_SEL];
						id_lock <= id_lock | sw_byte[`SEP_ST_ID_LOCK];
					end
					busy          <= 1'b1;
					busy_cnt      <= WRITE_CYCLES;
					was_write     <= 1'b0;
					write_start_o <= 1'b1;
				end
				if (state == S_WDATA && got_byte && bit_cnt == 4'h0 && ~frame_bad &&
					~(push_v & ~buf_in_ready)) begin
					busy          <= 1'b1;
					busy_cnt      <= WRITE_CYCLES;
					was_write     <= 1'b1;
					write_start_o <= 1'b1;
				end
				if (state == S_RDATA)
					id_sel <= 1'b0;
			end else if (sck_fall) begin
				so_o   <= out_sr[7];
				out_sr <= {out_sr[6:0], 1'b1};
			end else if (sck_rise) begin
				in_sr       <= in_byte;
				bit_cnt     <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
				latch_armed <= 1'b0;
				case (state)
					S_OPC: begin
						if (bit_cnt == 4'h7) begin
							opcode <= in_byte;
							if (busy && in_byte != `SEP_OP_STAT_READ)
								state <= S_IGNORE;
							else begin
								case (in_byte)
									`SEP_OP_SET_LATCH: begin
										latch_armed <= 1'b1;
										state       <= S_IGNORE;
									end
									`SEP_OP_CLR_LATCH: begin
										latch <= 1'b0;
										state <= S_IGNORE;
									end
									`SEP_OP_STAT_READ: begin
										out_sr <= status;
										state  <= S_SREAD;
									end
									`SEP_OP_STAT_WRITE: state <= S_SWRITE;
									`SEP_OP_MEM_READ:   state <= S_ADDR;
									`SEP_OP_MEM_WRITE:  state <= S_ADDR;
									default:            state <= S_IGNORE;
								endcase
							end
						end
					end
					S_ADDR: begin
						addr <= {addr[14:0], si_s[1]};
						if (bit_cnt == 4'h7 && got_byte) begin
							if (opcode == `SEP_OP_MEM_READ) begin
								state        <= S_RDATA;
								// last bit not yet shifted in, so the upper byte sits one place low
								rd_addr_o    <= id_sel ? {{(ADDR_W-ID_ADDR_W){1'b0}},
									in_byte[ID_ADDR_W-1:0]} : {addr[ADDR_W-2:7], in_byte};
								rd_id_page_o <= id_sel;
								rd_en_o      <= 1'b1;
							end else
								state <= S_WDATA;
							got_byte <= 1'b0;
						end else if (bit_cnt == 4'h7)
							got_byte <= 1'b1;
					end
					S_WDATA: begin
						if (bit_cnt == 4'h7) begin
							got_byte <= 1'b1;
							// id page ignores upper address, full array lock covers it
							if (~byte_ok)
								frame_bad <= 1'b1;
							else begin
								push_v <= 1'b1;
								push_d <= {id_sel, id_sel ? {{(ADDR_W-ID_ADDR_W){1'b0}},
									cur_addr[ID_ADDR_W-1:0]} : cur_addr, in_byte};
							end
							if (id_sel)
								addr[ID_ADDR_W-1:0] <= addr[ID_ADDR_W-1:0] + {{(ID_ADDR_W-1){1'b0}}, 1'b1};
							else
								addr[5:0] <= addr[5:0] + 6'h01;
						end
					end
					S_RDATA: begin
						if (bit_cnt == 4'h7) begin
							if (id_sel)
								rd_addr_o <= {{(ADDR_W-ID_ADDR_W){1'b0}},
									rd_addr_o[ID_ADDR_W-1:0] + {{(ID_ADDR_W-1){1'b0}}, 1'b1}};
							else
								rd_addr_o <= rd_addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
							rd_en_o <= 1'b1;
						end
					end
					S_SREAD: begin
						if (bit_cnt == 4'h7)
							out_sr <= status;
					end
					S_SWRITE: begin
						if (bit_cnt == 4'h7) begin
							if (got_byte)
								state <= S_IGNORE;
							got_byte <= 1'b1;
							sw_byte  <= in_byte;
						end
					end
					default: ;
				endcase
			end
			// memory answers one cycle after the read strobe
			if (rd_en_q)
				out_sr <= rd_data_i;
		end
	end

	always @(posedge clk_sys_i) begin
		if (srst_i)
			rd_en_q <= 1'b0;
		else
			rd_en_q <= rd_en_o;
	end

	// two entry write buffer, a receiver stall of one word loses nothing
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			buf_cnt    <= 2'h0;
			buf_mem1   <= {WORD_W{1'b0}};
			wr_word_o  <= {WORD_W{1'b0}};
			wr_valid_o <= 1'b0;
		end else begin
			case ({push_v & buf_in_ready, wr_valid_o & wr_ready_i})
				2'b10: begin
					if (buf_cnt == 2'h0)
						wr_word_o <= push_d;
					else
						buf_mem1 <= push_d;
					buf_cnt <= buf_cnt + 2'h1;
				end
				2'b01: begin
					wr_word_o <= buf_mem1;
					buf_cnt   <= buf_cnt - 2'h1;
				end
				2'b11: begin
					if (buf_cnt == 2'h1)
						wr_word_o <= push_d;
					else begin
						wr_word_o <= buf_mem1;
						buf_mem1  <= push_d;
					end
				end
				default: ;
			endcase
			wr_valid_o <= (buf_cnt != 2'h0 || push_v) && !(buf_cnt == 2'h1 &&
				wr_valid_o && wr_ready_i && !push_v) || (buf_cnt == 2'h2);
		end
	end

endmodule // sep_top

// ==== testbench/sep_sva.sv ====
// assertions on the spi front end ports
`timescale 1ns/100ps
module sep_sva (
	input wire       clk_sys_i,
	input wire       srst_i,
	input wire       cs_n_i,
	input wire       so_oe_o,
	input wire       write_start_o,
	input wire [7:0] status_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	sequence s_commit;
		write_start_o;
	endsequence
	sequence s_busy_up;
		##[1:3] status_o[0];
	endsequence
	// margin covers the two sync flops and the output register
	property p_oe_idle; cs_n_i [*5] |-> !so_oe_o; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
	property p_busy_up; s_commit |-> s_busy_up; endproperty
	a_busy_up: assert property (p_busy_up) else $error("busy missing after commit");
	property p_busy_len; $rose(status_o[0]) |-> status_o[0] [*8]; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy dropped early");
	property p_zero5; !status_o[5]; endproperty
	a_zero5: assert property (p_zero5) else $error("status bit five set");
	property p_latch_end; $fell(status_o[0]) |-> ##[0:2] !status_o[1]; endproperty
	a_latch_end: assert property (p_latch_end) else $error("latch kept after cycle");
	property p_start_latch; s_commit |-> $past(status_o[1]); endproperty
	a_start_latch: assert property (p_start_latch) else $error("commit without latch");
	property p_busy_quiet; status_o[0] && $past(status_o[0]) |-> !write_start_o; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("commit while busy");
	property p_nv_commit;
		$changed({status_o[7], status_o[4:2]}) |-> $past(write_start_o) || $past(write_start_o, 2);
	endproperty
	a_nv_commit: assert property (p_nv_commit) else $error("protect bits moved without commit");
endmodule // sep_sva

bind sep_top sep_sva u_sva (
	.clk_sys_i     (clk_sys_i),
	.srst_i        (srst_i),
	.cs_n_i        (cs_n_i),
	.so_oe_o       (so_oe_o),
	.write_start_o (write_start_o),
	.status_o      (status_o)
);

// ==== testbench/sep_mem_model.sv ====
// memory back end model: read data source and stalling write receiver
`timescale 1ns/100ps
module sep_mem_model (
	input  wire        clk_sys_i,
	input  wire        srst_i,
	input  wire [13:0] rd_addr_i,
	input  wire        rd_en_i,
	output reg  [7:0]  rd_data_o,
	input  wire [22:0] wr_word_i,
	input  wire        wr_valid_i,
	output wire        wr_ready_o,
	output reg  [22:0] last_word_o
);
	reg [1:0] stall;
	// ready one cycle in four; bytes come at least 64 clocks apart, so the buffer never fills
	assign wr_ready_o = (stall == 2'h3);
	always @(posedge clk_sys_i) begin
		stall <= srst_i ? 2'h0 : stall + 2'h1;
		// stale data is not held past its cycle
		if (rd_en_i) begin
			rd_data_o <= rd_addr_i[7:0] ^ 8'h5A;
		end else begin
			rd_data_o <= ~rd_data_o;
		end
		if (wr_valid_i && wr_ready_o) begin
			last_word_o <= wr_word_i;
		end
	end
endmodule // sep_mem_model

// ==== testbench/serial_eeprom_cmd_protect_tb_top.sv ====
// testbench for the spi command and protection front end
`timescale 1ns/100ps
module serial_eeprom_cmd_protect_tb_top;
	localparam WC = 300;
	reg         clk = 1'b0;
	reg         srst = 1'b1;
	reg         cs_n = 1'b1;
	reg         sck = 1'b0;
	reg         si = 1'b0;
	reg         wp_n = 1'b1;
	reg  [7:0]  rx = 8'h00;
	reg         hold_n = 1'b1;
	reg         mode3 = 1'b0;
	integer     pause_at = -1;
	reg  [7:0]  starts;
	integer     errors = 0;
	integer     check_count = 0;
	wire        so, so_oe, rd_en, rd_id, wr_valid, wr_ready, wstart;
	wire [13:0] rd_addr;
	wire [7:0]  rd_data, status;
	wire [22:0] wr_word, last_word;
	// released line reads as pulled up
	wire        so_line = so_oe ? so : 1'b1;

	always #12.5 clk = ~clk;

	sep_top #(.WRITE_CYCLES(WC)) u_dut (
		.clk_sys_i(clk), .srst_i(srst), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n),
		.wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .rd_addr_o(rd_addr), .rd_id_page_o(rd_id),
		.rd_en_o(rd_en), .rd_data_i(rd_data), .wr_word_o(wr_word), .wr_valid_o(wr_valid),
		.wr_ready_i(wr_ready), .write_start_o(wstart), .status_o(status)
	);
	sep_mem_model u_mem (
		.clk_sys_i(clk), .srst_i(srst), .rd_addr_i(rd_addr), .rd_en_i(rd_en), .rd_data_o(rd_data),
		.wr_word_i(wr_word), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .last_word_o(last_word)
	);

	always @(posedge clk) begin
		starts <= srst ? 8'h00 : starts + {7'h0, wstart};
	end

	task cyc(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task chk(input [22:0] g, input [22:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// one framed transfer, msb first, mode 0 or mode 3 as mode3 selects; rx keeps the last byte seen
	task fr(input [31:0] v, input integer nb);
		integer i;
		begin
			cs_n = 1'b0;
			cyc(4);
			for (i = nb - 1; i >= 0; i = i - 1) begin
				if (mode3)
					sck = 1'b0;
				si = v[i];
				cyc(4);
				sck = 1'b1;
				cyc(4);
				rx = {rx[6:0], so_line};
				if (!mode3)
					sck = 1'b0;
				// pause with the clock low; a clock pulse inside must be ignored
				if (i == pause_at && !mode3) begin
					cyc(4);
					chk({22'h0, so_oe}, 23'h1);
					hold_n = 1'b0;
					cyc(8);
					chk({22'h0, so_oe}, 23'h0);
					sck = 1'b1;
					cyc(4);
					sck = 1'b0;
					cyc(4);
					hold_n = 1'b1;
					cyc(4);
				end
			end
			cyc(4);
			cs_n = 1'b1;
			cyc(12);
		end
	endtask
	task rs(input [7:0] e);
		begin
			fr(32'h0500, 16);
			chk({15'h0, rx}, {15'h0, e});
		end
	endtask
	task summarize;
		begin
			$display("errors %0d checks %0d", errors, check_count);
			if (errors == 0 && check_count > 0) begin
				$display("*** PASS ***");
			end else begin
				$display("*** FAIL ***");
			end
			$finish;
		end
	endtask

	initial begin
		#1000000;
		errors = errors + 1;
		summarize;
	end

	initial begin
		cyc(8);
		srst = 1'b0;
		cyc(4);
		rs(8'h00);
		fr(32'h018C, 16);
		rs(8'h00);
		fr(32'h07, 8);
		rs(8'h00);
		fr(32'h06, 8);
		rs(8'h02);
		fr(32'h04, 8);
		rs(8'h00);
		fr(32'h06, 8);
		fr(32'h01AC, 16);
		fr(32'h04, 8);
		rs(8'h8F);
		cyc(WC);
		rs(8'h8C);
		pause_at = 4;
		rs(8'h8C);
		pause_at = -1;
		wp_n = 1'b0;
		fr(32'h06, 8);
		fr(32'h0100, 16);
		rs(8'h8E);
		wp_n = 1'b1;
		fr(32'h0104, 16);
		cyc(WC);
		rs(8'h04);
		sck = 1'b1;
		mode3 = 1'b1;
		cyc(4);
		rs(8'h04);
		mode3 = 1'b0;
		sck = 1'b0;
		cyc(4);
		fr(32'h06, 8);
		fr(32'h023000A5, 32);
		rs(8'h06);
		chk({15'h0, starts}, 23'h2);
		fr(32'h02EFFF3C, 32);
		cyc(WC);
		chk({15'h0, starts}, 23'h3);
		chk(last_word, {1'b0, 14'h2FFF, 8'h3C});
		rs(8'h04);
		fr(32'h03D23400, 32);
		chk({15'h0, rx}, 23'h6E);
		chk({8'h0, rd_id, rd_addr}, {8'h0, 1'b0, 14'h1235});
		fr(32'h06, 8);
		fr(32'h0154, 16);
		cyc(WC);
		fr(32'h04, 8);
		rs(8'h04);
		fr(32'h06, 8);
		fr(32'h0144, 16);
		cyc(WC);
		rs(8'h44);
		fr(32'h03FFC500, 32);
		chk({15'h0, rx}, 23'h5F);
		chk({8'h0, rd_id, rd_addr}, {8'h0, 1'b1, 14'h0006});
		rs(8'h04);
		summarize;
	end
endmodule // serial_eeprom_cmd_protect_tb_top
